// File: hpsm_regs.vh
// constants for the host power state manager
`ifndef HPSM_REGS_VH
`define HPSM_REGS_VH
// host-selectable led modes while on
`define HPSM_LED_OFF 2'h0
`define HPSM_LED_ON 2'h1
`define HPSM_LED_PULSE 2'h2
`define HPSM_LED_FLASH 2'h3
`define HPSM_LED_MODE_RST 2'h1
// default 7-bit target address
`define HPSM_I2C_ADDR_RST 7'h43
// power states
`define HPSM_ST_OFF 3'h0
`define HPSM_ST_BOOT 3'h1
`define HPSM_ST_ON 3'h2
`define HPSM_ST_SHDN 3'h3
`define HPSM_ST_WAIT 3'h4
// tick rate and default timings, in ticks
`define HPSM_CLK_HZ 40000000
`define HPSM_TICK_HZ 1000
`define HPSM_TICK_DIV (`HPSM_CLK_HZ / `HPSM_TICK_HZ)
`define HPSM_HOLD_TICKS 2000
`define HPSM_PULSE_TICKS 1000
`define HPSM_FLASH_TICKS 600
`define HPSM_FLASH_HALF 50
`define HPSM_OFF_DELAY_TICKS 2000
`endif

// File: hpsm_pwm.v
// led brightness pwm generator
`timescale 1ns/10ps
module hpsm_pwm #(
  parameter W = 8
) (
  core_clk,
  sys_rst,
  level,
  pwm_out
);
  input wire core_clk;
  input wire sys_rst;
  input wire [W-1:0] level;
  output reg pwm_out;

  reg [W-1:0] cnt_reg;

  always @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_reg <= {W{1'b0}};
      pwm_out <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
      pwm_out <= (cnt_reg < level);
    end
  end
endmodule // hpsm_pwm

// File: hpsm_core.v
// power state sequencer with touch, led and voltage supervision
`timescale 1ns/10ps
`include "hpsm_regs.vh"

// Functional notes
// RULE_01: act only after full press-and-hold
// RULE_02: led brightness ramps during hold
// RULE_03: ignore touch while booting or shutting
// RULE_04: slow pulse during boot and shutdown
// RULE_05: quick flash on touch while busy
// RULE_06: depleted battery requests shutdown, then cut
// RULE_07: returning power keeps host powered
// RULE_08: no auto boot by default
// RULE_09: auto boot on power return
// RULE_10: auto boot keeps host running
// RULE_11: refuse turn-on when battery depleted
// RULE_12: refuse turn-on when externally powered
// RULE_13: pulse until daemon reports running
// RULE_14: steady led when daemon runs
// RULE_15: compare voltages against programmable thresholds
// RULE_16: auto shutdown after usb absence time
// RULE_17: wake timer boots host after interval
// RULE_18: detect host shutdown completion
// RULE_19: target address default 0x43, configurable
// RULE_20: host led code selects on-state led
// RULE_21: timings are parameters in ticks
module hpsm_core #(
  parameter VW = 12,
  parameter TICK_DIV = `HPSM_TICK_DIV,
  parameter HOLD_TICKS = `HPSM_HOLD_TICKS, // RULE_21
  parameter PULSE_TICKS = `HPSM_PULSE_TICKS,
  parameter FLASH_TICKS = `HPSM_FLASH_TICKS,
  parameter FLASH_HALF = `HPSM_FLASH_HALF,
  parameter OFF_DELAY_TICKS = `HPSM_OFF_DELAY_TICKS
) (
  core_clk,
  sys_rst,
  touch_pin,
  host_running_pin,
  host_halted_pin,
  host_ext_power_pin,
  vusb_meas,
  vbat_meas,
  vout_meas,
  vusb_present_thr,
  vbat_boot_thr,
  vbat_shdn_thr,
  vbat_min_thr,
  auto_boot_en,
  auto_shdn_en,
  auto_shdn_ticks,
  wake_en,
  wake_ticks,
  led_mode,
  i2c_addr_wr,
  i2c_addr_in,
  i2c_addr,
  host_power_en,
  shutdown_req,
  power_status_led,
  charge_en,
  charging_indicator_led,
  power_state,
  vout_ok,
  touch_hist
);
  input wire core_clk;
  input wire sys_rst;
  input wire touch_pin;
  input wire host_running_pin;
  input wire host_halted_pin;
  input wire host_ext_power_pin;
  input wire [VW-1:0] vusb_meas;
  input wire [VW-1:0] vbat_meas;
  input wire [VW-1:0] vout_meas;
  input wire [VW-1:0] vusb_present_thr;
  input wire [VW-1:0] vbat_boot_thr;
  input wire [VW-1:0] vbat_shdn_thr;
  input wire [VW-1:0] vbat_min_thr;
  input wire auto_boot_en;
  input wire auto_shdn_en;
  input wire [15:0] auto_shdn_ticks;
  input wire wake_en;
  input wire [31:0] wake_ticks;
  input wire [1:0] led_mode;
  input wire i2c_addr_wr;
  input wire [6:0] i2c_addr_in;
  output reg [6:0] i2c_addr;
  output reg host_power_en;
  output reg shutdown_req;
  output wire power_status_led;
  output reg charge_en;
  output reg charging_indicator_led;
  output reg [2:0] power_state;
  output reg vout_ok;
  output reg [3:0] touch_hist;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  reg [3:0] sync1_reg;
  reg [3:0] sync2_reg;
  always @(posedge core_clk) begin
    if (sys_rst) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
    end else begin
      sync1_reg <= {host_ext_power_pin, host_halted_pin, host_running_pin, touch_pin};
      sync2_reg <= sync1_reg;
    end
  end
  wire touch_s = sync2_reg[0];
  wire running_s = sync2_reg[1];
  wire halted_s = sync2_reg[2];
  wire ext_s = sync2_reg[3];

  // ----------------------------------------------------------------
  // system tick
  // ----------------------------------------------------------------
  reg [31:0] div_reg;
  reg tick;
  always @(posedge core_clk) begin
    if (sys_rst) begin
      div_reg <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (div_reg == TICK_DIV - 1) begin
      div_reg <= 32'h0000_0000;
      tick <= 1'b1;
    end else begin
      div_reg <= div_reg + 32'h0000_0001;
      tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // voltage comparisons
  // ----------------------------------------------------------------
  wire usb_ok = (vusb_meas >= vusb_present_thr); // RULE_15
  wire bat_boot_ok = (vbat_meas >= vbat_boot_thr); // RULE_15
  wire bat_low = (vbat_meas < vbat_shdn_thr) && !usb_ok; // RULE_06 RULE_15
  wire bat_dead = (vbat_meas < vbat_min_thr) && !usb_ok; // RULE_15
  wire boot_allowed = (usb_ok || bat_boot_ok) && !ext_s;

  // ----------------------------------------------------------------
  // touch hold tracking
  // ----------------------------------------------------------------
  reg [31:0] hold_reg;
  reg hold_done_reg;
  reg touch_d_reg;
  wire touch_rise = touch_s && !touch_d_reg;
  always @(posedge core_clk) begin
    if (sys_rst) begin
      hold_reg <= 32'h0000_0000;
      hold_done_reg <= 1'b0;
      touch_d_reg <= 1'b0;
      touch_hist <= 4'h0;
    end else begin
      touch_d_reg <= touch_s;
      if (tick) begin
        touch_hist <= {touch_hist[2:0], touch_s};
      end
      // release resets the hold so short touches never count
      if (!touch_s) begin
        hold_reg <= 32'h0000_0000; // RULE_01
        hold_done_reg <= 1'b0;
      end else if (tick && !hold_done_reg) begin
        if (hold_reg == HOLD_TICKS - 1) begin
          hold_done_reg <= 1'b1; // RULE_01
        end
        hold_reg <= hold_reg + 32'h0000_0001;
      end
    end
  end
  // fires once per hold, the tick the delay completes
  wire hold_fire = tick && touch_s && !hold_done_reg && (hold_reg == HOLD_TICKS - 1);

  // ----------------------------------------------------------------
  // power state machine
  // ----------------------------------------------------------------
  reg [31:0] tmr_reg;
  reg [15:0] usb_gone_reg;
  reg [31:0] wake_reg;
  reg flash_req;
  reg usb_d_reg;
  wire usb_return = usb_ok && !usb_d_reg;
  wire busy = (power_state == `HPSM_ST_BOOT) || (power_state == `HPSM_ST_SHDN) ||
    (power_state == `HPSM_ST_WAIT);

  always @(posedge core_clk) begin
    if (sys_rst) begin
      power_state <= `HPSM_ST_OFF;
      host_power_en <= 1'b0;
      shutdown_req <= 1'b0;
      tmr_reg <= 32'h0000_0000;
      usb_gone_reg <= 16'h0000;
      wake_reg <= 32'h0000_0000;
      flash_req <= 1'b0;
      usb_d_reg <= 1'b0;
    end else begin
      usb_d_reg <= usb_ok;
      flash_req <= 1'b0;
      if (touch_rise && busy) begin
        flash_req <= 1'b1; // RULE_05
      end
      case (power_state)
        `HPSM_ST_OFF: begin
          host_power_en <= 1'b0;
          shutdown_req <= 1'b0;
          if (tick && wake_en && wake_reg != 32'h0000_0000) begin
            wake_reg <= wake_reg - 32'h0000_0001;
          end
          if (hold_fire && !boot_allowed) begin
            flash_req <= 1'b1; // RULE_11 RULE_12
          end else if (hold_fire ||
              (auto_boot_en && usb_return && !ext_s) || // RULE_08 RULE_09
              (auto_boot_en && boot_allowed) || // RULE_10
              (wake_en && wake_reg == 32'h0000_0001 && tick && boot_allowed)) begin // RULE_17
            power_state <= `HPSM_ST_BOOT;
            host_power_en <= 1'b1;
          end
        end
        `HPSM_ST_BOOT: begin // RULE_03
          // stays here until the daemon reports running or the battery is dead
          if (bat_dead) begin
            power_state <= `HPSM_ST_OFF;
            host_power_en <= 1'b0;
          end else if (running_s) begin
            power_state <= `HPSM_ST_ON; // RULE_13
          end
        end
        `HPSM_ST_ON: begin
          // input power returning keeps host powered, charger takes over
          host_power_en <= 1'b1; // RULE_07
          if (usb_ok) begin
            usb_gone_reg <= 16'h0000;
          end else if (tick && usb_gone_reg != 16'hffff) begin
            usb_gone_reg <= usb_gone_reg + 16'h0001;
          end
          if (hold_fire || bat_low || // RULE_06
              (auto_shdn_en && !usb_ok && usb_gone_reg >= auto_shdn_ticks)) begin // RULE_16
            power_state <= `HPSM_ST_SHDN;
            shutdown_req <= 1'b1;
          end
        end
        `HPSM_ST_SHDN: begin
          if (halted_s || bat_dead) begin
            power_state <= `HPSM_ST_WAIT; // RULE_18
            tmr_reg <= 32'h0000_0000;
          end
        end
        default: begin
          // grace time after halt before cutting the rail
          if (tick) begin
            tmr_reg <= tmr_reg + 32'h0000_0001;
          end
          if (tmr_reg >= OFF_DELAY_TICKS) begin
            power_state <= `HPSM_ST_OFF; // RULE_06
            host_power_en <= 1'b0;
            shutdown_req <= 1'b0;
            usb_gone_reg <= 16'h0000;
            wake_reg <= wake_ticks; // RULE_17
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // charger and address
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (sys_rst) begin
      charge_en <= 1'b0;
      charging_indicator_led <= 1'b0;
      i2c_addr <= `HPSM_I2C_ADDR_RST; // RULE_19
      vout_ok <= 1'b0;
    end else begin
      charge_en <= usb_ok; // RULE_07
      charging_indicator_led <= usb_ok && !bat_boot_ok;
      vout_ok <= (vout_meas >= vbat_min_thr);
      if (i2c_addr_wr) begin
        i2c_addr <= i2c_addr_in; // RULE_19
      end
    end
  end

  // ----------------------------------------------------------------
  // led pattern generation
  // ----------------------------------------------------------------
  reg [31:0] pulse_reg;
  reg [31:0] flash_reg;
  reg [7:0] level_reg;
  reg [7:0] level_next;
  wire [31:0] half_p = PULSE_TICKS / 2;
  wire [31:0] tri_p = (pulse_reg < half_p) ? pulse_reg : (PULSE_TICKS - 1 - pulse_reg);
  wire [31:0] tri_s = (tri_p * 255) / (half_p == 0 ? 1 : half_p);
  wire [31:0] ramp_s = (hold_reg * 255) / HOLD_TICKS;
  wire flash_on = ((flash_reg / FLASH_HALF) % 2) == 1;
  // host fast flash reuses the refusal half period on the pulse counter, so it only shows while PULSE_TICKS exceeds FLASH_HALF
  wire fast_on = ((pulse_reg / FLASH_HALF) % 2) == 1;
  always @(posedge core_clk) begin
    if (sys_rst) begin
      pulse_reg <= 32'h0000_0000;
      flash_reg <= 32'h0000_0000;
      level_reg <= 8'h00;
    end else begin
      if (tick) begin
        pulse_reg <= (pulse_reg >= PULSE_TICKS - 1) ? 32'h0000_0000 : pulse_reg + 32'h0000_0001;
      end
      if (flash_req) begin
        flash_reg <= FLASH_TICKS; // RULE_05
      end else if (tick && flash_reg != 32'h0000_0000) begin
        flash_reg <= flash_reg - 32'h0000_0001;
      end
      level_reg <= level_next;
    end
  end
  always @* begin
    level_next = 8'h00;
    if (flash_reg != 32'h0000_0000) begin
      level_next = flash_on ? 8'hff : 8'h00; // RULE_05 RULE_11 RULE_12
    end else if (busy) begin
      level_next = tri_s[7:0]; // RULE_04 RULE_13
    end else if (touch_s && !hold_done_reg) begin
      level_next = ramp_s[7:0]; // RULE_02
    end else if (power_state == `HPSM_ST_ON) begin
      case (led_mode) // RULE_20
        `HPSM_LED_OFF: level_next = 8'h00;
        `HPSM_LED_ON: level_next = 8'hff; // RULE_14
        `HPSM_LED_PULSE: level_next = tri_s[7:0];
        default: level_next = fast_on ? 8'hff : 8'h00; // RULE_20
      endcase
    end
  end

  hpsm_pwm #(.W(8)) u_pwm (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .level(level_reg),
    .pwm_out(power_status_led)
  );
endmodule // hpsm_core

// File: hpsm_core_props.sv
// concurrent checks on the host power state manager core ports
`timescale 1ns/10ps
`include "hpsm_regs.vh"
module hpsm_core_props #(
  parameter TICK_DIV = 4,
  parameter HOLD_TICKS = 8
) (
  input wire core_clk,
  input wire sys_rst,
  input wire touch_pin,
  input wire host_running_pin,
  input wire host_halted_pin,
  input wire host_ext_power_pin,
  input wire auto_boot_en,
  input wire wake_en,
  input wire i2c_addr_wr,
  input wire [6:0] i2c_addr_in,
  input wire [6:0] i2c_addr,
  input wire host_power_en,
  input wire shutdown_req,
  input wire [2:0] power_state
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // length of the latest touch run, so a short hold count shows up
  reg touch_prev;
  reg [31:0] run_len;
  always @(posedge core_clk) begin
    touch_prev <= touch_pin;
    if (touch_pin) run_len <= touch_prev ? run_len + 32'h0000_0001 : 32'h0000_0001;
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  sequence touch_boot_s;
    power_state == `HPSM_ST_OFF && !auto_boot_en && !wake_en ##1 power_state == `HPSM_ST_BOOT;
  endsequence
  sequence to_on_s;
    power_state == `HPSM_ST_BOOT ##1 power_state == `HPSM_ST_ON;
  endsequence
  sequence to_wait_s;
    power_state == `HPSM_ST_SHDN ##1 power_state == `HPSM_ST_WAIT;
  endsequence
  sequence to_cut_s;
    power_state == `HPSM_ST_WAIT ##1 power_state == `HPSM_ST_OFF;
  endsequence
  addr_reset_a: assert property ($fell(sys_rst) |-> i2c_addr == `HPSM_I2C_ADDR_RST)
    else $error("address not at reset value");
  addr_load_a: assert property (i2c_addr_wr |=> i2c_addr == $past(i2c_addr_in))
    else $error("address write not taken");
  hold_boot_a: assert property (touch_boot_s |-> run_len >= (HOLD_TICKS - 1) * TICK_DIV)
    else $error("boot without full hold");
  boot_exit_a: assert property ($past(power_state) == `HPSM_ST_BOOT |->
    power_state inside {`HPSM_ST_BOOT, `HPSM_ST_ON, `HPSM_ST_OFF}) else $error("left boot wrongly");
  shdn_exit_a: assert property ($past(power_state) == `HPSM_ST_SHDN |->
    power_state inside {`HPSM_ST_SHDN, `HPSM_ST_WAIT}) else $error("left shutdown wrongly");
  run_to_on_a: assert property (to_on_s |-> $past(host_running_pin, 2))
    else $error("on without daemon report");
  halt_to_wait_a: assert property (to_wait_s |-> $past(host_halted_pin, 2))
    else $error("wait without host halt");
  shdn_flag_a: assert property (power_state == `HPSM_ST_SHDN [*2] |-> shutdown_req)
    else $error("no shutdown request");
  power_cut_a: assert property (to_cut_s |-> ##[0:2] !host_power_en)
    else $error("power not removed");
  on_power_a: assert property (power_state == `HPSM_ST_ON |-> host_power_en)
    else $error("host unpowered while on");
  ext_refuse_a: assert property (power_state == `HPSM_ST_OFF && host_ext_power_pin [*4]
    |=> power_state == `HPSM_ST_OFF) else $error("boot while externally powered");
endmodule // hpsm_core_props

bind hpsm_core hpsm_core_props #(.TICK_DIV(TICK_DIV), .HOLD_TICKS(HOLD_TICKS)) hpsm_core_props_inst (
  .core_clk(core_clk), .sys_rst(sys_rst), .touch_pin(touch_pin),
  .host_running_pin(host_running_pin), .host_halted_pin(host_halted_pin),
  .host_ext_power_pin(host_ext_power_pin), .auto_boot_en(auto_boot_en), .wake_en(wake_en),
  .i2c_addr_wr(i2c_addr_wr), .i2c_addr_in(i2c_addr_in), .i2c_addr(i2c_addr),
  .host_power_en(host_power_en), .shutdown_req(shutdown_req), .power_state(power_state));

// File: hpsm_host_model.sv
// behavioural host computer with its power daemon
`timescale 1ns/10ps
module hpsm_host_model #(
  parameter BOOT_CYC = 3000,
  parameter HALT_CYC = 100
) (
  input wire core_clk,
  input wire host_power_en,
  input wire shutdown_req,
  input wire daemon_en,
  output reg host_running_pin = 1'b0,
  output reg host_halted_pin = 1'b0
);
  reg [15:0] up_cnt = 16'h0000;
  reg [15:0] halt_cnt = 16'h0000;
  always @(posedge core_clk) begin
    if (!host_power_en) begin
      // an unpowered host reports nothing
      up_cnt <= 16'h0000;
      halt_cnt <= 16'h0000;
      host_running_pin <= 1'b0;
      host_halted_pin <= 1'b0;
    end else begin
      if (up_cnt < BOOT_CYC) up_cnt <= up_cnt + 16'h0001;
      // without the daemon installed the host never reports running
      host_running_pin <= up_cnt == BOOT_CYC && daemon_en && !host_halted_pin;
      if (shutdown_req && halt_cnt < HALT_CYC) halt_cnt <= halt_cnt + 16'h0001;
      host_halted_pin <= halt_cnt == HALT_CYC;
    end
  end
endmodule // hpsm_host_model

// File: test_host_power_state_manager.sv
// self-checking testbench for the host power state manager
`timescale 1ns/10ps
`include "hpsm_regs.vh"
module test_host_power_state_manager;
  reg core_clk = 1'b0, sys_rst = 1'b1, touch_pin = 1'b0, host_ext_power_pin = 1'b0;
  reg auto_boot_en = 1'b0, auto_shdn_en = 1'b0, wake_en = 1'b0, i2c_addr_wr = 1'b0;
  reg daemon_en = 1'b1;
  reg [11:0] vusb_meas = 12'h900, vbat_meas = 12'h700;
  reg [11:0] vout_meas = 12'h700, vusb_thr = 12'h800, vboot_thr = 12'h600;
  reg [11:0] vshdn_thr = 12'h500, vmin_thr = 12'h400;
  reg [15:0] auto_shdn_ticks = 16'h0000;
  reg [31:0] wake_ticks = 32'h0000_0000;
  reg [1:0] led_mode = 2'h1;
  reg [6:0] i2c_addr_in = 7'h00;
  wire [6:0] i2c_addr;
  wire [2:0] power_state;
  wire host_power_en, shutdown_req, power_status_led, charge_en, run_pin, halt_pin;
  wire charging_indicator_led, vout_ok;
  wire [3:0] touch_hist;
  integer miscompares = 0, samples_checked = 0;
  always #12.5 core_clk = ~core_clk;
  hpsm_core #(.TICK_DIV(4), .HOLD_TICKS(256), .PULSE_TICKS(16), .FLASH_TICKS(12),
    .FLASH_HALF(2)) hpsm_core_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .touch_pin(touch_pin),
    .host_running_pin(run_pin), .host_halted_pin(halt_pin),
    .host_ext_power_pin(host_ext_power_pin), .vusb_meas(vusb_meas), .vbat_meas(vbat_meas),
    .vout_meas(vout_meas), .vusb_present_thr(vusb_thr), .vbat_boot_thr(vboot_thr),
    .vbat_shdn_thr(vshdn_thr), .vbat_min_thr(vmin_thr), .auto_boot_en(auto_boot_en),
    .auto_shdn_en(auto_shdn_en), .auto_shdn_ticks(auto_shdn_ticks), .wake_en(wake_en),
    .wake_ticks(wake_ticks), .led_mode(led_mode), .i2c_addr_wr(i2c_addr_wr),
    .i2c_addr_in(i2c_addr_in), .i2c_addr(i2c_addr), .host_power_en(host_power_en),
    .shutdown_req(shutdown_req), .power_status_led(power_status_led), .charge_en(charge_en),
    .charging_indicator_led(charging_indicator_led), .power_state(power_state),
    .vout_ok(vout_ok), .touch_hist(touch_hist));
  hpsm_host_model hpsm_host_model_inst (.core_clk(core_clk), .host_power_en(host_power_en),
    .shutdown_req(shutdown_req), .daemon_en(daemon_en), .host_running_pin(run_pin),
    .host_halted_pin(halt_pin));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task chk(input string name, input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge core_clk);
  endtask
  task wait_st(input [2:0] s, input integer lim);
    integer n;
    begin
      n = 0;
      while (power_state !== s && n < lim) begin
        @(negedge core_clk);
        n = n + 1;
      end
      chk("state", power_state, s);
    end
  endtask
  task press(input integer n);
    begin
      @(posedge core_clk) touch_pin <= 1'b1;
      repeat (n) @(posedge core_clk);
      touch_pin <= 1'b0;
    end
  endtask
  // hold past the delay and watch the led while a refusal shows
  task refuse(output [1:0] c);
    begin
      @(posedge core_clk) touch_pin <= 1'b1;
      cyc(1040);
      led_cls(40, c);
      @(posedge core_clk) touch_pin <= 1'b0;
    end
  endtask
  task sup(input [11:0] u, input [11:0] b);
    begin
      @(posedge core_clk) vusb_meas <= u;
      vbat_meas <= b;
    end
  endtask
  // led class: 0 dark, 1 steady, 2 changing
  task led_cls(input integer n, output [1:0] c);
    integer h;
    begin
      h = 0;
      repeat (n) begin
        @(negedge core_clk);
        h = h + power_status_led;
      end
      c = h == 0 ? 2'h0 : (h > n - n / 16 ? 2'h1 : 2'h2);
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d miscompares %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin : main
    integer lo, hi, m;
    reg [1:0] c;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    cyc(1);
    chk("addr", i2c_addr, `HPSM_I2C_ADDR_RST);
    chk("power", host_power_en, 1'b0);
    @(posedge core_clk) i2c_addr_in <= 7'h2a;
    i2c_addr_wr <= 1'b1;
    @(posedge core_clk) i2c_addr_wr <= 1'b0;
    cyc(1);
    chk("addr", i2c_addr, 7'h2a);
    chk("vout", vout_ok, 1'b1);
    chk("chg led", charging_indicator_led, 1'b0);
    press(200);
    cyc(60);
    chk("state", power_state, `HPSM_ST_OFF);
    chk("hist", touch_hist, 4'h0);
    $display("test reset and short touch done");
    @(posedge core_clk) touch_pin <= 1'b1;
    lo = 0;
    hi = 0;
    // the brightness ramps, so the second 400 cycles of the hold are brighter than the first
    repeat (400) @(negedge core_clk) lo = lo + power_status_led;
    chk("hist", touch_hist, 4'hf);
    repeat (400) @(negedge core_clk) hi = hi + power_status_led;
    chk("ramp", hi > lo, 1);
    wait_st(`HPSM_ST_BOOT, 600);
    @(posedge core_clk) touch_pin <= 1'b0;
    chk("power", host_power_en, 1'b1);
    press(1100);
    chk("state", power_state, `HPSM_ST_BOOT);
    led_cls(300, c);
    chk("busy led", c, 2'h2);
    wait_st(`HPSM_ST_ON, 3000);
    for (m = 0; m < 4; m = m + 1) begin
      @(posedge core_clk) led_mode <= m;
      cyc(8);
      led_cls(512, c);
      chk("led mode", c, m > 1 ? 2 : m);
    end
    @(posedge core_clk) led_mode <= 2'h1;
    $display("test touch boot and led done");
    sup(12'h100, 12'h700);
    cyc(200);
    chk("charge", charge_en, 1'b0);
    @(posedge core_clk) vout_meas <= 12'h300;
    cyc(3);
    chk("vout", vout_ok, 1'b0);
    @(posedge core_clk) vout_meas <= 12'h700;
    sup(12'h900, 12'h700);
    cyc(20);
    chk("charge", charge_en, 1'b1);
    chk("state", power_state, `HPSM_ST_ON);
    sup(12'h100, 12'h480);
    wait_st(`HPSM_ST_SHDN, 100);
    chk("request", shutdown_req, 1'b1);
    wait_st(`HPSM_ST_WAIT, 200);
    wait_st(`HPSM_ST_OFF, `HPSM_OFF_DELAY_TICKS * 4 + 100);
    cyc(3);
    chk("power", host_power_en, 1'b0);
    sup(12'h900, 12'h700);
    cyc(300);
    chk("state", power_state, `HPSM_ST_OFF);
    $display("test power loss done");
    sup(12'h100, 12'h300);
    refuse(c);
    chk("flash", c, 2'h2);
    cyc(20);
    chk("state", power_state, `HPSM_ST_OFF);
    sup(12'h900, 12'h300);
    cyc(4);
    chk("chg led", charging_indicator_led, 1'b1);
    sup(12'h900, 12'h700);
    @(posedge core_clk) host_ext_power_pin <= 1'b1;
    refuse(c);
    chk("flash", c, 2'h2);
    cyc(20);
    chk("state", power_state, `HPSM_ST_OFF);
    @(posedge core_clk) host_ext_power_pin <= 1'b0;
    $display("test refusals done");
    @(posedge core_clk) daemon_en <= 1'b0;
    auto_boot_en <= 1'b1;
    wait_st(`HPSM_ST_BOOT, 50);
    led_cls(3500, c);
    chk("pulse", c, 2'h2);
    chk("state", power_state, `HPSM_ST_BOOT);
    @(posedge core_clk) daemon_en <= 1'b1;
    wait_st(`HPSM_ST_ON, 100);
    sup(12'h100, 12'h700);
    cyc(200);
    chk("state", power_state, `HPSM_ST_ON);
    @(posedge core_clk) auto_boot_en <= 1'b0;
    auto_shdn_ticks <= 16'h000a;
    wake_ticks <= 32'h0000_0028;
    wake_en <= 1'b1;
    auto_shdn_en <= 1'b1;
    wait_st(`HPSM_ST_SHDN, 80);
    wait_st(`HPSM_ST_WAIT, 200);
    wait_st(`HPSM_ST_OFF, `HPSM_OFF_DELAY_TICKS * 4 + 100);
    cyc(100);
    chk("state", power_state, `HPSM_ST_OFF);
    wait_st(`HPSM_ST_BOOT, 120);
    $display("test auto modes done");
    @(posedge core_clk) sys_rst <= 1'b1;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    cyc(1);
    chk("addr", i2c_addr, `HPSM_I2C_ADDR_RST);
    chk("state", power_state, `HPSM_ST_OFF);
    $display("test second reset done");
    report_and_stop;
  end
  initial begin : watchdog
    repeat (60000) @(posedge core_clk);
    miscompares = miscompares + 1;
    report_and_stop;
  end
endmodule // test_host_power_state_manager
